// ===== ilv_pkg.sv
// shared constants, register map and helpers for the interleaved pcm bus port
package ilv_pkg;
	// device register offsets
	localparam logic [7:0] OFF_ILV_CFG = 8'h1c; // interleave_bus_config
	localparam logic [7:0] OFF_SYNC_CFG = 8'h1d; // tx sync pin direction
	localparam logic [7:0] OFF_DEV_STAT = 8'h1e; // device status
	// interleave_bus_config fields
	localparam int BIT_SPARE = 7;
	localparam int BIT_TCS = 6;
	localparam int BIT_RATE_HI = 5;
	localparam int BIT_RATE_LO = 4;
	localparam int BIT_EN = 3;
	localparam int BIT_POS_HI = 2;
	localparam int BIT_POS_LO = 0;
	localparam logic [7:0] ILV_CFG_RST = 8'h00;
	localparam logic [7:0] SPARE_CLEAR = 8'h7f;
	localparam int BIT_SYNC_OUT = 0;
	localparam logic SYNC_CFG_RST = 1'b0;
	// controller register offsets
	localparam logic [7:0] OFF_CTL = 8'h00;
	localparam logic [7:0] OFF_TAKEN = 8'h04;
	localparam logic [7:0] OFF_DADDR = 8'h08;
	localparam logic [7:0] OFF_DDATA = 8'h0c;
	localparam logic [7:0] OFF_DREAD = 8'h10;
	localparam logic [7:0] OFF_STAT = 8'h14;
	localparam int BIT_ES = 0;
	localparam int BIT_RUN = 1;
	localparam int BIT_CRATE_LO = 2;
	localparam int BIT_CRATE_HI = 3;
	localparam int BIT_XS_VAL = 4;
	localparam int BIT_XS_EN = 5;
	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [7:0] TAKEN_RST = 8'h00;
	localparam int BIT_ERR_ES = 0;
	localparam int BIT_ERR_POS = 1;
	localparam int BIT_ACTIVE = 2;
	// data path
	localparam int DATA_W = 8;
	localparam int ES_DEPTH = 32; // channels per e1 frame
	localparam logic [7:0] IDLE_BYTE = 8'hff;
	localparam int CHANNELS = 32;
	// bus timing: clock cycles per bus slot at 100 ns
	localparam int CLK_NS = 100;
	localparam int SLOT_NS = 400;
	localparam int SLOT_CYCLES = (SLOT_NS + CLK_NS - 1) / CLK_NS;

	// slot mask for the rate code: devices on bus minus one
	function automatic logic [2:0] pos_mask(input logic [1:0] rate);
		unique case (rate)
			2'h0: pos_mask = 3'h0;
			2'h1: pos_mask = 3'h1;
			2'h2: pos_mask = 3'h3;
			2'h3: pos_mask = 3'h7;
		endcase
	endfunction : pos_mask
endpackage : ilv_pkg

// ===== ilv_if.sv
// link between the transceiver end and the backplane controller end
`timescale 1ns/1ns
interface ilv_if (
	input wire logic clk,
	input wire logic rst_n
);
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic es_enable;
	logic slot_strobe;
	logic rx_frame_sync;
	logic [7:0] ctl_dout;
	logic [7:0] dev_dout;
	logic dev_oe;
	logic dev_tsync_out;
	logic dev_tsync_oe;
	logic ctl_tsync_out;
	logic ctl_tsync_oe;
	logic tsync_level;

	// resolved tx sync wire; undriven reads low
	assign tsync_level = dev_tsync_oe ? dev_tsync_out : (ctl_tsync_oe & ctl_tsync_out);

	modport device (
		input clk, rst_n, reg_addr, reg_wdata, reg_wr, reg_rd, es_enable,
		input slot_strobe, rx_frame_sync, ctl_dout, tsync_level,
		output reg_rdata, dev_dout, dev_oe, dev_tsync_out, dev_tsync_oe
	);
	modport ctl (
		input clk, rst_n, reg_rdata, dev_dout, dev_oe, dev_tsync_oe, tsync_level,
		output reg_addr, reg_wdata, reg_wr, reg_rd, es_enable,
		output slot_strobe, rx_frame_sync, ctl_dout, ctl_tsync_out, ctl_tsync_oe
	);
endinterface : ilv_if

// ===== ilv_fifo.sv
// receive elastic store: parameterised fifo with valid/ready on both sides
`timescale 1ns/1ns
module ilv_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic [AW:0] cnt_d;
	logic push;
	logic pop;

	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem[rd_q];

	// count next value, flags registered so ready is a flop
	always_comb begin
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q <= '0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			in_ready <= (cnt_d != (AW+1)'(DEPTH));
			out_valid <= (cnt_d != '0);
		end
	end

	// pointers; storage itself needs no reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end
endmodule : ilv_fifo

// ===== ilv_device.sv
// transceiver end: interleave config register, slot placement, tx sync and tx clock
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// How it works
// - rate field sets bus speed and device count
// - interleave whole channel bytes, never single bits
// - controller enables elastic store before interleaving
// - each transceiver owns one exclusive bus position
// - controller never drives tx sync while interleaving; here it drives the pin low unless the device drove it the cycle before
// - interleaving ties internal tx sync to rx sync
// - tx sync pin input ignored while interleaving
// - bit 6 picks tx clock pin or backplane
// - bit 3 enables interleave, else normal mode
// - bits 2..0 pick one of eight positions
// - software keeps spare bit 7 at zero
module ilv_device (
	ilv_if.device lnk,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	output logic rx_ready,
	output logic [7:0] tx_data,
	output logic tx_valid,
	output logic tx_frame_start,
	input wire logic tx_clock_pin,
	input wire logic backplane_clock_pin,
	output logic tx_clock_out
);
	logic clk;
	logic rst_n;
	logic [7:0] cfg_q;
	logic sync_cfg_q;
	logic [7:0] rdata_q;
	logic [7:0] slot_cnt_q;
	logic [7:0] dout_q;
	logic oe_q;
	logic [7:0] txd_q;
	logic txv_q;
	logic txfs_q;
	logic tsync_out_q;
	logic tsync_oe_q;
	logic tx_clock_pin_q;
	logic interleave_enable;
	logic tx_clock_source_select;
	logic [1:0] rate;
	logic [2:0] position;
	logic [7:0] slot_idx;
	logic own_slot;
	logic tsync_int;
	logic [7:0] es_data;
	logic es_valid;
	logic es_pop;
	logic es_ready;

	assign clk = lnk.clk;
	assign rst_n = lnk.rst_n;

	////////////////////////////////////////////////////////////////////////////
	// register fields
	assign interleave_enable = cfg_q[ilv_pkg::BIT_EN];
	assign tx_clock_source_select = cfg_q[ilv_pkg::BIT_TCS];
	assign rate = cfg_q[ilv_pkg::BIT_RATE_HI:ilv_pkg::BIT_RATE_LO];
	assign position = cfg_q[ilv_pkg::BIT_POS_HI:ilv_pkg::BIT_POS_LO];

	// register writes; spare bit is stored as written
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfg_q <= ilv_pkg::ILV_CFG_RST;
			sync_cfg_q <= ilv_pkg::SYNC_CFG_RST;
		end else if (lnk.reg_wr) begin
			if (lnk.reg_addr == ilv_pkg::OFF_ILV_CFG) begin
				cfg_q <= lnk.reg_wdata;
			end
			if (lnk.reg_addr == ilv_pkg::OFF_SYNC_CFG) begin
				sync_cfg_q <= lnk.reg_wdata[ilv_pkg::BIT_SYNC_OUT];
			end
		end
	end

	// read data one cycle after the strobe, zero otherwise and when unmapped
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
		end else if (lnk.reg_rd) begin
			unique case (lnk.reg_addr)
				ilv_pkg::OFF_ILV_CFG: rdata_q <= cfg_q;
				ilv_pkg::OFF_SYNC_CFG: rdata_q <= {7'h00, sync_cfg_q};
				ilv_pkg::OFF_DEV_STAT: rdata_q <= {5'h00, lnk.es_enable, !es_ready, es_valid};
				default: rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// elastic store between the receive framer and the bus
	ilv_fifo #(
		.WIDTH(ilv_pkg::DATA_W),
		.DEPTH(ilv_pkg::ES_DEPTH)
	) u_es (
		.clk(clk),
		.rst_n(rst_n),
		.in_data(rx_data),
		.in_valid(rx_valid),
		.in_ready(es_ready),
		.out_data(es_data),
		.out_valid(es_valid),
		.out_ready(es_pop)
	);
	assign rx_ready = es_ready; // flop inside the store

	////////////////////////////////////////////////////////////////////////////
	// slot counting: frame sync arrives with the strobe of slot 0
	assign slot_idx = lnk.rx_frame_sync ? 8'h00 : slot_cnt_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			slot_cnt_q <= 8'h00;
		end else if (lnk.slot_strobe) begin
			slot_cnt_q <= slot_idx + 8'h01;
		end
	end

	// positions beyond the device count never match, so no slot is shared
	assign own_slot = interleave_enable
		? ((slot_idx[2:0] & ilv_pkg::pos_mask(rate)) == position)
		: 1'b1; // normal mode owns every slot
	assign es_pop = lnk.slot_strobe & own_slot & es_valid;

	// a whole channel byte per owned slot; drive held for the slot
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dout_q <= ilv_pkg::IDLE_BYTE;
			oe_q <= 1'b0;
		end else if (lnk.slot_strobe) begin
			oe_q <= own_slot;
			dout_q <= es_valid ? es_data : ilv_pkg::IDLE_BYTE;
		end
	end

	// transmit side takes the backplane byte of its own slot
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			txd_q <= 8'h00;
			txv_q <= 1'b0;
		end else begin
			txv_q <= lnk.slot_strobe & own_slot;
			if (lnk.slot_strobe && own_slot) begin
				txd_q <= lnk.ctl_dout;
			end
		end
	end
	assign lnk.dev_dout = dout_q;
	assign lnk.dev_oe = oe_q;
	assign tx_data = txd_q;
	assign tx_valid = txv_q;

	////////////////////////////////////////////////////////////////////////////
	// internal tx sync: pin only counts in normal mode with the pin as input
	always_comb begin
		if (interleave_enable) begin
			tsync_int = lnk.rx_frame_sync;
		end else if (sync_cfg_q) begin
			tsync_int = lnk.rx_frame_sync;
		end else begin
			tsync_int = lnk.tsync_level;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			txfs_q <= 1'b0;
			tsync_out_q <= 1'b0;
			tsync_oe_q <= 1'b0;
		end else begin
			txfs_q <= tsync_int;
			tsync_out_q <= tsync_int;
			tsync_oe_q <= sync_cfg_q;
		end
	end
	assign tx_frame_start = txfs_q;
	assign lnk.dev_tsync_out = tsync_out_q;
	assign lnk.dev_tsync_oe = tsync_oe_q;
	assign lnk.reg_rdata = rdata_q;

	////////////////////////////////////////////////////////////////////////////
	// tx clock source; both clock pins are sampled levels here
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_clock_pin_q <= 1'b0;
		end else begin
			tx_clock_pin_q <= tx_clock_source_select ? backplane_clock_pin : tx_clock_pin;
		end
	end
	assign tx_clock_out = tx_clock_pin_q;
endmodule : ilv_device

// ===== ilv_ctl.sv
// backplane controller end: slot timing, device setup guards, tx sync pin
//
// Design decision made here: strobed register access.
`timescale 1ns/1ns
module ilv_ctl (
	ilv_if.ctl lnk,
	input wire logic [7:0] sw_addr,
	input wire logic [7:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [7:0] sw_rdata,
	output logic [7:0] bus_byte,
	output logic bus_byte_valid
);
	logic clk;
	logic rst_n;
	logic [7:0] ctl_q;
	logic [7:0] taken_q;
	logic [7:0] daddr_q;
	logic [7:0] dread_q;
	logic rd_pend_q;
	logic [1:0] stat_q;
	logic active_q;
	logic [7:0] rdata_q;
	logic [7:0] ra_q;
	logic [7:0] rw_q;
	logic wr_q;
	logic rd_q;
	logic [2:0] div_q;
	logic [7:0] slot_q;
	logic strobe_q;
	logic fsync_q;
	logic [7:0] dout_q;
	logic tso_q;
	logic tsoe_q;
	logic [7:0] cap_q;
	logic capv_q;
	logic [7:0] clean;
	logic cfg_write;
	logic bad_es;
	logic bad_pos;
	logic [7:0] last_slot;

	assign clk = lnk.clk;
	assign rst_n = lnk.rst_n;

	////////////////////////////////////////////////////////////////////////////
	// guards on writes to the device's interleave config
	assign clean = sw_wdata & ilv_pkg::SPARE_CLEAR;
	assign cfg_write = sw_wr & (sw_addr == ilv_pkg::OFF_DDATA) & (daddr_q == ilv_pkg::OFF_ILV_CFG);
	assign bad_es = clean[ilv_pkg::BIT_EN] & !ctl_q[ilv_pkg::BIT_ES];
	assign bad_pos = clean[ilv_pkg::BIT_EN] & taken_q[clean[2:0]];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctl_q <= ilv_pkg::CTL_RST;
			taken_q <= ilv_pkg::TAKEN_RST;
			daddr_q <= 8'h00;
			active_q <= 1'b0;
		end else if (sw_wr) begin
			if (sw_addr == ilv_pkg::OFF_CTL) ctl_q <= sw_wdata;
			if (sw_addr == ilv_pkg::OFF_TAKEN) taken_q <= sw_wdata;
			if (sw_addr == ilv_pkg::OFF_DADDR) daddr_q <= sw_wdata;
			if (cfg_write && !bad_es && !bad_pos) active_q <= clean[ilv_pkg::BIT_EN];
		end
	end

	// device access issue: refused config writes never reach the device
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ra_q <= 8'h00;
			rw_q <= 8'h00;
			wr_q <= 1'b0;
			rd_q <= 1'b0;
		end else begin
			wr_q <= sw_wr & (sw_addr == ilv_pkg::OFF_DDATA) & !(cfg_write & (bad_es | bad_pos));
			rd_q <= sw_wr & (sw_addr == ilv_pkg::OFF_DREAD);
			if (sw_wr) begin
				ra_q <= daddr_q;
				rw_q <= cfg_write ? clean : sw_wdata;
			end
		end
	end

	// device answers one cycle after its read strobe
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_pend_q <= 1'b0;
			dread_q <= 8'h00;
		end else begin
			rd_pend_q <= rd_q;
			if (rd_pend_q) dread_q <= lnk.reg_rdata;
		end
	end

	// sticky refusal flags, write one to clear, a new refusal wins
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stat_q <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (sw_wr && sw_addr == ilv_pkg::OFF_STAT && sw_wdata[i]) stat_q[i] <= 1'b0;
			end
			if (cfg_write && bad_es) stat_q[ilv_pkg::BIT_ERR_ES] <= 1'b1;
			if (cfg_write && bad_pos && !bad_es) stat_q[ilv_pkg::BIT_ERR_POS] <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
		end else if (sw_rd) begin
			unique case (sw_addr)
				ilv_pkg::OFF_CTL: rdata_q <= ctl_q;
				ilv_pkg::OFF_TAKEN: rdata_q <= taken_q;
				ilv_pkg::OFF_DADDR: rdata_q <= daddr_q;
				ilv_pkg::OFF_DDATA: rdata_q <= dread_q;
				ilv_pkg::OFF_STAT: rdata_q <= {5'h00, active_q, stat_q};
				default: rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// slot timing; runs only with elastic store enabled
	assign last_slot = 8'((ilv_pkg::CHANNELS << ctl_q[ilv_pkg::BIT_CRATE_HI:ilv_pkg::BIT_CRATE_LO]) - 1);

	always_ff @(posedge clk) begin
		if (!rst_n || !(ctl_q[ilv_pkg::BIT_RUN] && ctl_q[ilv_pkg::BIT_ES])) begin
			div_q <= 3'h0;
			slot_q <= 8'h00;
			strobe_q <= 1'b0;
			fsync_q <= 1'b0;
			dout_q <= 8'h00;
		end else begin
			strobe_q <= (div_q == 3'(ilv_pkg::SLOT_CYCLES - 1));
			fsync_q <= (div_q == 3'(ilv_pkg::SLOT_CYCLES - 1)) && (slot_q == 8'h00);
			if (div_q == 3'(ilv_pkg::SLOT_CYCLES - 1)) begin
				div_q <= 3'h0;
				dout_q <= slot_q;
				slot_q <= (slot_q >= last_slot) ? 8'h00 : slot_q + 8'h01;
			end else begin
				div_q <= div_q + 3'h1;
			end
		end
	end

	// sample what the device drove over the previous slot
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cap_q <= 8'h00;
			capv_q <= 1'b0;
		end else begin
			capv_q <= strobe_q & lnk.dev_oe;
			if (strobe_q && lnk.dev_oe) cap_q <= lnk.dev_dout;
		end
	end

	// tx sync pin: held at ground while interleaving, released a cycle after the device drives it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tso_q <= 1'b0;
			tsoe_q <= 1'b0;
		end else begin
			tso_q <= active_q ? 1'b0 : ctl_q[ilv_pkg::BIT_XS_VAL];
			tsoe_q <= !lnk.dev_tsync_oe & (active_q | ctl_q[ilv_pkg::BIT_XS_EN]);
		end
	end

	assign lnk.reg_addr = ra_q;
	assign lnk.reg_wdata = rw_q;
	assign lnk.reg_wr = wr_q;
	assign lnk.reg_rd = rd_q;
	assign lnk.es_enable = ctl_q[ilv_pkg::BIT_ES];
	assign lnk.slot_strobe = strobe_q;
	assign lnk.rx_frame_sync = fsync_q;
	assign lnk.ctl_dout = dout_q;
	assign lnk.ctl_tsync_out = tso_q;
	assign lnk.ctl_tsync_oe = tsoe_q;
	assign sw_rdata = rdata_q;
	assign bus_byte = cap_q;
	assign bus_byte_valid = capv_q;
endmodule : ilv_ctl

// ===== ilv_link_properties.sv
// link checker: forwarded config writes, slot ownership, slot timing and tx sync drive
`timescale 1ns/1ns
module ilv_link_properties (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic es_enable,
	input wire logic slot_strobe,
	input wire logic rx_frame_sync,
	input wire logic [7:0] dev_dout,
	input wire logic dev_oe,
	input wire logic dev_tsync_oe,
	input wire logic ctl_tsync_out,
	input wire logic ctl_tsync_oe
);
	logic [7:0] cfg_q;
	logic [7:0] idx_q;
	logic seen_q;
	logic [2:0] mask;
	logic [7:0] cur;
	logic own;
	logic cfg_wr;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////////////
	// shadow of the device config, taken from forwarded writes only
	assign cfg_wr = reg_wr && (reg_addr == ilv_pkg::OFF_ILV_CFG);
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfg_q <= 8'h00;
		end else if (cfg_wr) begin
			cfg_q <= reg_wdata;
		end
	end

	// own slot counter; ownership is unknown until the first frame sync
	assign mask = 3'((4'h1 << cfg_q[5:4]) - 4'h1);
	assign cur = rx_frame_sync ? 8'h00 : idx_q + 8'h01;
	assign own = (cur[2:0] & mask) == cfg_q[2:0];
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			idx_q <= 8'h00;
			seen_q <= 1'b0;
		end else if (slot_strobe) begin
			idx_q <= cur;
			seen_q <= seen_q | rx_frame_sync;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	a_slot_owned: assert property (slot_strobe && (seen_q || rx_frame_sync) && cfg_q[3] && own
		|=> dev_oe) else $error("owned slot not driven");
	a_slot_foreign: assert property (slot_strobe && (seen_q || rx_frame_sync) && cfg_q[3] && !own
		|=> !dev_oe) else $error("foreign slot driven");
	a_normal_every: assert property (slot_strobe && !cfg_q[3] |=> dev_oe)
		else $error("normal mode slot not driven");
	a_byte_hold: assert property (!slot_strobe |=> $stable(dev_oe) && $stable(dev_dout))
		else $error("bus byte changed inside a slot");
	a_slot_spacing: assert property (slot_strobe |=> !slot_strobe [*3] ##1 slot_strobe)
		else $error("slot spacing wrong");
	a_store_first: assert property (cfg_wr && reg_wdata[ilv_pkg::BIT_EN] |-> es_enable)
		else $error("interleave enabled with store off");
	a_spare_clear: assert property (cfg_wr |-> !reg_wdata[ilv_pkg::BIT_SPARE])
		else $error("spare bit written as one");
	a_no_ext_sync: assert property (cfg_q[3] && $past(cfg_q[3]) && !reg_wr && !dev_tsync_oe
		|-> !(ctl_tsync_oe && ctl_tsync_out)) else $error("tx sync driven high");
endmodule : ilv_link_properties

// ===== tb.sv
// testbench: both link ends, software port, store fill and drain, slot and sync traffic
`timescale 1ns/1ns
module tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] sw_addr = 8'h00;
	logic [7:0] sw_wdata = 8'h00;
	logic sw_wr = 1'b0;
	logic sw_rd = 1'b0;
	logic [7:0] sw_rdata;
	logic [7:0] bus_byte;
	logic bus_byte_valid;
	logic [7:0] rx_data = 8'h00;
	logic rx_valid = 1'b0;
	logic rx_ready;
	logic [7:0] tx_data;
	logic tx_valid;
	logic tx_frame_start;
	logic tx_clock_pin = 1'b0;
	logic backplane_clock_pin = 1'b0;
	logic tx_clock_out;
	logic fs_prev = 1'b0;
	logic fs_chk = 1'b0;
	int seed = 97658;
	int rnd;
	int fail_count = 0;
	int cmp_count = 0;
	int slot_n = 0;
	logic [7:0] byte_q[$];

	always #50 clk = ~clk;

	ilv_if lnk (.clk(clk), .rst_n(rst_n));
	ilv_device ilv_device_inst (.lnk(lnk), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_frame_start(tx_frame_start), .tx_clock_pin(tx_clock_pin),
		.backplane_clock_pin(backplane_clock_pin), .tx_clock_out(tx_clock_out));
	ilv_ctl ilv_ctl_inst (.lnk(lnk), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
		.sw_rd(sw_rd), .sw_rdata(sw_rdata), .bus_byte(bus_byte),
		.bus_byte_valid(bus_byte_valid));
	ilv_link_properties ilv_link_properties_inst (.clk(lnk.clk), .rst_n(lnk.rst_n),
		.reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata), .reg_wr(lnk.reg_wr),
		.es_enable(lnk.es_enable), .slot_strobe(lnk.slot_strobe),
		.rx_frame_sync(lnk.rx_frame_sync), .dev_dout(lnk.dev_dout), .dev_oe(lnk.dev_oe),
		.dev_tsync_oe(lnk.dev_tsync_oe), .ctl_tsync_out(lnk.ctl_tsync_out),
		.ctl_tsync_oe(lnk.ctl_tsync_oe));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// slot bytes on the bus and towards transmit
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		chk(got, exp);
	endtask : chk_byte

	// single-bit results: frame start and tx clock
	task automatic chk_bit(input logic got, input logic exp);
		chk({7'h00, got}, {7'h00, exp});
	endtask : chk_bit

	task automatic stop_test();
		if (fail_count == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test

	// one-cycle strobes; a gap cycle keeps each strobe a single assignment per step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge clk);
		sw_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge clk);
		sw_rd <= 1'b0;
		@(posedge clk);
		chk(sw_rdata, exp);
	endtask : rd

	task automatic dwr(input logic [7:0] a, input logic [7:0] d);
		wr(ilv_pkg::OFF_DADDR, a);
		wr(ilv_pkg::OFF_DDATA, d);
	endtask : dwr

	// device data lands three cycles after the read trigger
	task automatic drd(input logic [7:0] a, input logic [7:0] exp);
		wr(ilv_pkg::OFF_DADDR, a);
		wr(ilv_pkg::OFF_DREAD, 8'h00);
		repeat (3) @(posedge clk);
		rd(ilv_pkg::OFF_DDATA, exp);
	endtask : drd

	// both clock pins toggle at random; the output follows the selected one a cycle late
	task automatic check_clk(input logic tcs);
		logic p;
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			if (i > 0)
				chk_bit(tx_clock_out, p);
			p = tcs ? backplane_clock_pin : tx_clock_pin;
			rnd = $random(seed);
			tx_clock_pin <= rnd[0];
			backplane_clock_pin <= rnd[1];
		end
	endtask : check_clk

	////////////////////////////////////////////////////////////////////////////////
	// bus byte model: store head in order, idle byte once the store is empty
	// slot_n counts slots from frame sync; an owned slot hands its number to transmit
	always @(posedge clk) begin
		if (bus_byte_valid === 1'b1)
			chk_byte(bus_byte, byte_q.size() > 0 ? byte_q.pop_front() : ilv_pkg::IDLE_BYTE);
		if (tx_valid === 1'b1)
			chk_byte(tx_data, 8'(slot_n));
		if (fs_chk)
			chk_bit(tx_frame_start, fs_prev);
		if (lnk.slot_strobe === 1'b1)
			slot_n = lnk.rx_frame_sync ? 0 : slot_n + 1;
		fs_prev <= lnk.rx_frame_sync;
	end

	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		stop_test();
	end

	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd(ilv_pkg::OFF_CTL, ilv_pkg::CTL_RST);
		rd(ilv_pkg::OFF_TAKEN, ilv_pkg::TAKEN_RST);
		rd(8'h20, 8'h00);
		drd(ilv_pkg::OFF_ILV_CFG, ilv_pkg::ILV_CFG_RST);
		drd(ilv_pkg::OFF_SYNC_CFG, 8'h00);
		// interleave request with the store still off is held back
		dwr(ilv_pkg::OFF_ILV_CFG, 8'h08);
		rd(ilv_pkg::OFF_STAT, 8'h01);
		drd(ilv_pkg::OFF_ILV_CFG, 8'h00);
		wr(ilv_pkg::OFF_STAT, 8'h01);
		wr(ilv_pkg::OFF_CTL, 8'h01);
		// fill the store while no slots run, until it refuses
		rnd = $random(seed);
		rx_data <= rnd[7:0];
		rx_valid <= 1'b1;
		for (int i = 0; i < 40; i++) begin
			@(posedge clk);
			if (rx_ready === 1'b1) begin
				byte_q.push_back(rx_data);
				rnd = $random(seed);
				rx_data <= rnd[7:0];
			end
		end
		rx_valid <= 1'b0;
		chk(8'(byte_q.size()), 8'(ilv_pkg::ES_DEPTH));
		drd(ilv_pkg::OFF_DEV_STAT, 8'h07);
		dwr(ilv_pkg::OFF_ILV_CFG, 8'hc0);
		drd(ilv_pkg::OFF_ILV_CFG, 8'h40);
		check_clk(1'b1);
		// normal mode: every slot drains the store, then idle bytes
		wr(ilv_pkg::OFF_CTL, 8'h07);
		repeat (300) @(posedge clk);
		drd(ilv_pkg::OFF_DEV_STAT, 8'h04);
		// a position already taken is refused
		wr(ilv_pkg::OFF_TAKEN, 8'h02);
		dwr(ilv_pkg::OFF_ILV_CFG, 8'h19);
		rd(ilv_pkg::OFF_STAT, 8'h02);
		wr(ilv_pkg::OFF_STAT, 8'h02);
		dwr(ilv_pkg::OFF_ILV_CFG, 8'h18);
		rd(ilv_pkg::OFF_STAT, 8'h04);
		drd(ilv_pkg::OFF_ILV_CFG, 8'h18);
		check_clk(1'b0);
		fs_chk = 1'b1;
		// external sync asked for while interleaving must not reach the frame start;
		// both ends step through every rate, the pin a device output for the first four
		wr(ilv_pkg::OFF_TAKEN, 8'h00);
		for (int i = 0; i < 8; i++) begin
			wr(ilv_pkg::OFF_CTL, {4'h3, 2'(i), 2'b11});
			dwr(ilv_pkg::OFF_SYNC_CFG, {7'h00, 1'(i < 4)});
			dwr(ilv_pkg::OFF_ILV_CFG, {2'b00, 2'(i), 1'b1, 3'(i)});
			repeat (300) @(posedge clk);
		end
		fs_chk = 1'b0;
		// normal mode with the pin as input: frame start follows the pin
		dwr(ilv_pkg::OFF_ILV_CFG, 8'h00);
		repeat (4) @(posedge clk);
		chk_bit(tx_frame_start, 1'b1);
		wr(ilv_pkg::OFF_CTL, 8'h27);
		repeat (4) @(posedge clk);
		chk_bit(tx_frame_start, 1'b0);
		// second reset in mid-run
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd(ilv_pkg::OFF_CTL, ilv_pkg::CTL_RST);
		drd(ilv_pkg::OFF_ILV_CFG, ilv_pkg::ILV_CFG_RST);
		stop_test();
	end
endmodule : tb
